// ===== tenbase_t_phy_pkg.sv
/*
 * Shared constants and carrier types for the 10 Mb/s twisted-pair PHY core:
 * clock-derived timing counts, link monitor limits and the packed structs of
 * the MAC-side and line-side signal groups.
 * Assumes a single system clock of 40 MHz; all timing counts derive from CLK_MHZ.
 */
package tenbase_t_phy_pkg;

    // system clock
    localparam int unsigned CLK_MHZ        = 40;

    // line bit timing: 100 ns per bit, two half-bit phases
    localparam int unsigned BIT_NS         = 100;
    localparam int unsigned BIT_CYC        = (BIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HALF_CYC       = BIT_CYC / 2;

    // MAC-side interface clocks, in kHz
    localparam int unsigned MII_CLK_KHZ    = 2500;
    localparam int unsigned SER_CLK_KHZ    = 10000;
    localparam int unsigned MII_DIV_CYC    = CLK_MHZ * 1000 / MII_CLK_KHZ;
    localparam int unsigned SER_DIV_CYC    = CLK_MHZ * 1000 / SER_CLK_KHZ;
    localparam int unsigned DIV_W          = 4;

    // link pulses: one every 16 ms, 100 ns wide
    localparam int unsigned NLP_PERIOD_MS  = 16;
    localparam int unsigned NLP_PERIOD_CYC = NLP_PERIOD_MS * CLK_MHZ * 1000;
    localparam int unsigned NLP_W          = 20;
    localparam int unsigned NLP_WIDTH_NS   = 100;
    localparam int unsigned NLP_WIDTH_CYC  = (NLP_WIDTH_NS * CLK_MHZ + 999) / 1000;
    // longest energy burst still taken as a received link pulse
    localparam int unsigned NLP_MAX_NS     = 300;
    localparam int unsigned NLP_MAX_CYC    = NLP_MAX_NS * CLK_MHZ / 1000;
    localparam int unsigned BURST_W        = 4;
    localparam int unsigned NLP_VALID_CNT  = 7;

    // end-of-packet idle marker held high on the line
    localparam int unsigned IDL_NS         = 200;
    localparam int unsigned IDL_CYC        = (IDL_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned IDL_W          = 4;

    // link loss after 82 ms of silence, inside the 81..83 ms window
    localparam int unsigned LINK_LOSS_US   = 82000;
    localparam int unsigned LINK_LOSS_CYC  = LINK_LOSS_US * CLK_MHZ;
    localparam int unsigned LOSS_W         = 22;

    // receive clock recovery
    localparam int unsigned LOCK_BITS      = 3;
    localparam int unsigned MID_MIN_CYC    = BIT_CYC - 1;
    localparam int unsigned END_GAP_CYC    = BIT_CYC * 3 / 2 + 1;
    localparam int unsigned GAP_W          = 3;

    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } mac_tx_t;

    typedef struct packed {
        logic       dv;
        logic [3:0] data;
    } mac_rx_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic drive;
    } line_tx_t;

endpackage : tenbase_t_phy_pkg

// ===== manchester_rx_decoder.sv
/*
 * Receive clock recovery and Manchester decoding for the 10 Mb/s line.
 * Assumes lineLvl is already synchronised to clk_sys and that a bit lasts
 * BIT_CYC system clocks; every mid-bit transition re-times the recovery.
 */
module manchester_rx_decoder
    import tenbase_t_phy_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic lineLvl,
    output logic      bitStb,
    output logic      bitVal,
    output logic      locked,
    output logic      frameEnd,
    output logic      idlOk
);

    logic             prevLvl_reg;
    logic [GAP_W-1:0] gapCnt_reg;
    logic [1:0]       goodCnt_reg;
    logic [1:0]       goodCnt_next;
    logic             bitStb_reg;
    logic             bitVal_reg;
    logic             locked_reg;
    logic             frameEnd_reg;
    logic             idlOk_reg;

    // a transition far enough from the last mid-bit one is the next mid-bit
    wire edgeSeen = lineLvl ^ prevLvl_reg;
    wire midEdge  = edgeSeen && (gapCnt_reg >= GAP_W'(MID_MIN_CYC));
    // no mid-bit edge for 1.5 bits ends the frame; an idle line never counts
    wire gapOut   = !edgeSeen && (gapCnt_reg == GAP_W'(END_GAP_CYC - 1)) && (goodCnt_reg != 2'h0);

    // consecutive good bits, saturating at the lock threshold
    assign goodCnt_next = gapOut ? 2'h0 :
                          (midEdge && goodCnt_reg != 2'(LOCK_BITS)) ? goodCnt_reg + 2'h1 : goodCnt_reg;

    // recovery state; a one is high first, so the level before the edge is the bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prevLvl_reg  <= 1'b0;
            gapCnt_reg   <= GAP_W'(END_GAP_CYC);
            goodCnt_reg  <= 2'h0;
            bitStb_reg   <= 1'b0;
            bitVal_reg   <= 1'b0;
            locked_reg   <= 1'b0;
            frameEnd_reg <= 1'b0;
            idlOk_reg    <= 1'b0;
        end else begin
            prevLvl_reg  <= lineLvl;
            gapCnt_reg   <= midEdge ? GAP_W'(1) :
                            (gapCnt_reg == GAP_W'(END_GAP_CYC)) ? gapCnt_reg : gapCnt_reg + GAP_W'(1);
            goodCnt_reg  <= goodCnt_next;
            bitStb_reg   <= midEdge;
            bitVal_reg   <= midEdge ? prevLvl_reg : bitVal_reg;
            locked_reg   <= (goodCnt_next == 2'(LOCK_BITS));
            frameEnd_reg <= gapOut && locked_reg;
            idlOk_reg    <= gapOut && locked_reg && lineLvl;     // line still high: idle marker
        end
    end

    assign bitStb   = bitStb_reg;
    assign bitVal   = bitVal_reg;
    assign locked   = locked_reg;
    assign frameEnd = frameEnd_reg;
    assign idlOk    = idlOk_reg;

endmodule : manchester_rx_decoder

// ===== tenbase_t_phy_core.sv
/*
 * Digital core of a 10 Mb/s twisted-pair PHY: Manchester transmit with idle
 * marker and link pulses, receive decoding, MII nibble or serial MAC side,
 * carrier sense, collision and the link monitor with latching-low status.
 * Assumes the MAC runs on clk_sys and changes transmit inputs away from the
 * cycle in which txClk rises; line receive pins are asynchronous.
 */
module tenbase_t_phy_core
    import tenbase_t_phy_pkg::*;
#(
    parameter int unsigned NLP_PERIOD_CYC_P = NLP_PERIOD_CYC,
    parameter int unsigned LINK_LOSS_CYC_P  = LINK_LOSS_CYC
)(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 serialMode,
    input  wire logic                 fullDuplex,
    input  wire logic                 repeaterMode,
    input  wire logic                 noiseCheckInhibit,
    input  wire logic                 statusRead,
    input  wire tenbase_t_phy_pkg::mac_tx_t  macTx,
    output logic                      txClk,
    output tenbase_t_phy_pkg::mac_rx_t       macRx,
    output logic                      rxClk,
    output logic                      crs,
    output logic                      col,
    output tenbase_t_phy_pkg::line_tx_t      lineTx,
    input  wire logic                 lineRxLvl,
    input  wire logic                 lineRxAct,
    output logic                      linkValid,
    output logic                      linkStatusBasic,
    output logic                      linkStatusFast
);

    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_IDL} tx_state_t;
    typedef enum logic [1:0] {LINK_FAIL, LINK_HOLD, LINK_OK} link_state_t;

    // last count of the interface clock divider for the selected interface
    function automatic logic [DIV_W-1:0] divLast(input logic ser);
        divLast = ser ? DIV_W'(SER_DIV_CYC - 1) : DIV_W'(MII_DIV_CYC - 1);
    endfunction : divLast

    // half period of the selected interface clock
    function automatic logic [DIV_W-1:0] divHalf(input logic ser);
        divHalf = ser ? DIV_W'(SER_DIV_CYC / 2) : DIV_W'(MII_DIV_CYC / 2);
    endfunction : divHalf

    tx_state_t         txState_reg;
    tx_state_t         txState_next;
    logic [DIV_W-1:0]  txDiv_reg;
    logic              txClk_reg;
    logic              serPrev_reg;
    logic [3:0]        txShift_reg;
    logic [IDL_W-1:0]  idlCnt_reg;
    logic [NLP_W-1:0]  nlpTimer_reg;
    line_tx_t          lineTx_reg;
    logic [1:0]        syncA_reg;
    logic [1:0]        syncB_reg;
    logic              actPrev_reg;
    logic [BURST_W-1:0] burst_reg;
    logic              bitStb;
    logic              bitVal;
    logic              rxLocked;
    logic              frameEnd;
    logic              idlOk;
    logic [3:0]        rxShift_reg;
    logic [1:0]        rxBitCnt_reg;
    mac_rx_t           macRx_reg;
    logic              rxClk_reg;
    logic [DIV_W-1:0]  rxLow_reg;
    link_state_t       link_reg;
    link_state_t       link_next;
    logic [2:0]        nlpCnt_reg;
    logic [LOSS_W-1:0] lossCnt_reg;
    logic              statusLatch_reg;
    logic              statusLatch_next;
    logic              crs_reg;
    logic              col_reg;

    // transmit divider: interface clock edge and bit phase
    // a mode change restarts the divider so no short high phase reaches the MAC
    wire              modeChg  = serialMode ^ serPrev_reg;
    wire              divWrap  = (txDiv_reg == divLast(serialMode));
    wire [DIV_W-1:0]  txDivNx  = (divWrap || modeChg) ? DIV_W'(0) : txDiv_reg + DIV_W'(1);
    wire              txSample = (txDiv_reg == DIV_W'(0));
    // bit position counts from the capture edge, so bit0 gets all four phases
    wire [DIV_W-1:0]  txPos    = txDiv_reg - DIV_W'(1);
    wire [1:0]        bitPhase = txPos[1:0];
    wire [1:0]        bitIdx   = serialMode ? 2'h0 : txPos[3:2];
    wire              curBit   = txShift_reg[bitIdx];
    wire              firstHalf = (bitPhase < 2'(HALF_CYC));
    wire              txBusy   = (txState_reg != TX_IDLE);

    // transmit sequencing: data, then the idle marker, then idle
    always_comb begin
        txState_next = txState_reg;
        case (txState_reg)
            TX_IDLE: if (txSample && macTx.en) txState_next = TX_DATA;
            TX_DATA: if (txSample && !macTx.en) txState_next = TX_IDL;
            TX_IDL:  if (idlCnt_reg == IDL_W'(IDL_CYC - 1)) txState_next = TX_IDLE;
            default: txState_next = TX_IDLE;
        endcase
    end

    // line level for the coming cycle
    wire nlpNow   = (txState_reg == TX_IDLE) && (nlpTimer_reg < NLP_W'(NLP_WIDTH_CYC));
    wire dataLvl  = firstHalf ? curBit : !curBit;
    wire txLevel  = (txState_reg == TX_DATA) ? dataLvl : 1'b1;
    wire txDrive  = (txState_reg != TX_IDLE) || nlpNow;

    // interface clock and nibble/serial capture at its rising edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txDiv_reg   <= DIV_W'(MII_DIV_CYC - 1);
            txClk_reg   <= 1'b0;
            txShift_reg <= 4'h0;
            txState_reg <= TX_IDLE;
            serPrev_reg <= 1'b0;
        end else begin
            txDiv_reg   <= txDivNx;
            serPrev_reg <= serialMode;
            txClk_reg   <= (txDivNx < divHalf(serialMode));
            txState_reg <= txState_next;
            if (txSample && macTx.en) begin
                txShift_reg <= serialMode ? {3'h0, macTx.data[0]} : macTx.data;
            end
        end
    end

    // idle marker length and link pulse period; pulses restart after a frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idlCnt_reg   <= IDL_W'(0);
            nlpTimer_reg <= NLP_W'(0);
        end else begin
            idlCnt_reg   <= (txState_reg == TX_IDL) ? idlCnt_reg + IDL_W'(1) : IDL_W'(0);
            if (txBusy || nlpTimer_reg == NLP_W'(NLP_PERIOD_CYC_P - 1)) begin
                nlpTimer_reg <= NLP_W'(0);
            end else begin
                nlpTimer_reg <= nlpTimer_reg + NLP_W'(1);
            end
        end
    end

    // differential line drive, registered so the pins never glitch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lineTx_reg <= '0;
        end else begin
            lineTx_reg.pos   <= txDrive && txLevel;
            lineTx_reg.neg   <= txDrive && !txLevel;
            lineTx_reg.drive <= txDrive;
        end
    end

    // two-stage synchronisers for the receive level and energy detect
    wire [1:0] rxPins = {lineRxAct, lineRxLvl};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    syncA_reg[gi] <= 1'b0;
                    syncB_reg[gi] <= 1'b0;
                end else begin
                    syncA_reg[gi] <= rxPins[gi];
                    syncB_reg[gi] <= syncA_reg[gi];
                end
            end
        end
    endgenerate

    wire rxLvl = syncB_reg[0];
    wire rxAct = syncB_reg[1];

    manchester_rx_decoder u_decoder (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .lineLvl  (rxLvl),
        .bitStb   (bitStb),
        .bitVal   (bitVal),
        .locked   (rxLocked),
        .frameEnd (frameEnd),
        .idlOk    (idlOk)
    );

    // a short energy burst without lock is a received link pulse
    wire actFall = actPrev_reg && !rxAct;
    wire nlpSeen = actFall && !rxLocked && (burst_reg <= BURST_W'(NLP_MAX_CYC));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            actPrev_reg <= 1'b0;
            burst_reg   <= BURST_W'(0);
        end else begin
            actPrev_reg <= rxAct;
            if (!rxAct) begin
                burst_reg <= BURST_W'(0);
            end else if (burst_reg != {BURST_W{1'b1}}) begin
                burst_reg <= burst_reg + BURST_W'(1);
            end
        end
    end

    // receive assembly; the idle marker has no mid-bit edges, so it never
    // produces bits and is stripped here
    wire rxStb = bitStb && rxLocked && (serialMode || rxBitCnt_reg == 2'h3);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxShift_reg  <= 4'h0;
            rxBitCnt_reg <= 2'h0;
            macRx_reg    <= '0;
        end else begin
            if (!rxLocked) begin
                rxBitCnt_reg <= 2'h0;
                macRx_reg.dv <= 1'b0;
            end else if (bitStb) begin
                rxShift_reg  <= {bitVal, rxShift_reg[3:1]};
                rxBitCnt_reg <= rxBitCnt_reg + 2'h1;
            end
            if (rxStb) begin
                macRx_reg.dv   <= 1'b1;
                macRx_reg.data <= serialMode ? {3'h0, bitVal} : {bitVal, rxShift_reg[3:1]};
            end
        end
    end

    // recovered receive clock: falls with new data, rises mid-way for the MAC
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxClk_reg <= 1'b1;
            rxLow_reg <= DIV_W'(0);
        end else if (rxStb) begin
            rxClk_reg <= 1'b0;
            rxLow_reg <= divHalf(serialMode) - DIV_W'(1);
        end else if (rxLow_reg != DIV_W'(0)) begin
            rxLow_reg <= rxLow_reg - DIV_W'(1);
        end else begin
            rxClk_reg <= 1'b1;
        end
    end

    // link monitor; a frame counts when the noise check is off or it ended in the idle marker
    wire goodEnd  = frameEnd && (noiseCheckInhibit || idlOk);
    wire lossDone = (lossCnt_reg == LOSS_W'(LINK_LOSS_CYC_P - 1));

    always_comb begin
        link_next = link_reg;
        case (link_reg)
            LINK_FAIL: begin
                if (nlpSeen && nlpCnt_reg == 3'(NLP_VALID_CNT)) link_next = LINK_OK;
                else if (rxLocked) link_next = LINK_HOLD;
            end
            LINK_HOLD: if (frameEnd) link_next = goodEnd ? LINK_OK : LINK_FAIL;
            LINK_OK:   if (lossDone && !nlpSeen && !goodEnd) link_next = LINK_FAIL;
            default:   link_next = LINK_FAIL;
        endcase
    end

    wire linkDrop = (link_reg == LINK_OK) && (link_next != LINK_OK);

    // a drop clears the latch and wins over a read in the same cycle
    assign statusLatch_next = linkDrop   ? 1'b0 :
                              statusRead ? (link_reg == LINK_OK) :
                              statusLatch_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_reg        <= LINK_FAIL;
            nlpCnt_reg      <= 3'h0;
            lossCnt_reg     <= LOSS_W'(0);
            statusLatch_reg <= 1'b0;
        end else begin
            link_reg        <= link_next;
            nlpCnt_reg      <= (link_reg != LINK_FAIL) ? 3'h0 : nlpCnt_reg + {2'h0, nlpSeen};
            lossCnt_reg     <= (link_reg != LINK_OK || nlpSeen || goodEnd) ? LOSS_W'(0)
                             : lossCnt_reg + LOSS_W'(1);
            statusLatch_reg <= statusLatch_next;
        end
    end

    // carrier and collision; own link pulses never raise either
    wire crsNext = (fullDuplex || repeaterMode) ? rxLocked : (rxLocked || txBusy);
    wire colNext = !fullDuplex && txBusy && rxLocked;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crs_reg <= 1'b0;
            col_reg <= 1'b0;
        end else begin
            crs_reg <= crsNext;
            col_reg <= colNext;
        end
    end

    assign txClk           = txClk_reg;
    assign macRx           = macRx_reg;
    assign rxClk           = rxClk_reg;
    assign crs             = crs_reg;
    assign col             = col_reg;
    assign lineTx          = lineTx_reg;
    assign linkValid       = (link_reg == LINK_OK);
    assign linkStatusBasic = statusLatch_reg;
    assign linkStatusFast  = statusLatch_reg;

    // checks
    a_one_halves: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txState_reg == TX_DATA && bitPhase == 2'h0 && curBit && txState_next == TX_DATA)
        |=> lineTx.pos ##2 lineTx.neg)
        else $error("one not sent high then low");

    a_zero_halves: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txState_reg == TX_DATA && bitPhase == 2'h0 && !curBit && txState_next == TX_DATA)
        |=> lineTx.neg ##2 lineTx.pos)
        else $error("zero not sent low then high");

    a_serial_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($rose(txClk) && serialMode) ##1 serialMode[*4] |-> $rose(txClk))
        else $error("serial clock period wrong");

    a_nibble_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($rose(txClk) && !serialMode) ##1 (!serialMode)[*7] |-> txClk)
        else $error("nibble clock high time wrong");

    a_pulse_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txState_reg == TX_IDLE && nlpTimer_reg == NLP_W'(0) && !macTx.en)
        |=> lineTx.drive && lineTx.pos)
        else $error("link pulse not started");

    a_valid_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(macRx.dv) |-> $past(rxLocked))
        else $error("data handed over without lock");

    a_hold_waits: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (link_reg == LINK_HOLD && !frameEnd) |=> !linkValid)
        else $error("link valid before packet end");

    a_latch_no_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!statusRead && !linkStatusBasic) |=> !linkStatusFast)
        else $error("latched status rose without a read");

    a_read_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (statusRead && linkValid && !linkDrop) |=> linkStatusBasic)
        else $error("read did not reload status");

    a_loss_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (linkValid && lossDone && !nlpSeen && !goodEnd) |=> !linkValid ##1 !linkStatusBasic)
        else $error("silent link not dropped");

    a_full_no_col: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fullDuplex ##1 fullDuplex |-> !col)
        else $error("collision in full duplex");

    a_half_crs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (txBusy && !fullDuplex && !repeaterMode) |=> crs)
        else $error("carrier missing while sending");

endmodule : tenbase_t_phy_core

// ===== mac_tx_model.sv
/* MAC-side transmit model: offers one nibble per interface clock period.
   assumes the core samples macTx where txClk rises. */
module mac_tx_model
    import tenbase_t_phy_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    txClk,
    input  wire logic                    go,
    input  wire logic [3:0]              nib,
    output tenbase_t_phy_pkg::mac_tx_t   macTx
);
    timeunit 1ns;
    timeprecision 1ps;
    // update only while txClk is low, so the request stands across its rise
    always_ff @(posedge clk_sys) begin
        if (!txClk) begin
            macTx <= '{en: go, data: go ? nib : ~nib};
        end
    end
endmodule : mac_tx_model

// ===== tb_tenbase_t_phy_core.sv
/* bench for the 10 Mb/s PHY core: line coding, interface clocks, link monitor, carrier.
   assumes shortened pulse and loss counts; the MAC side is mac_tx_model. */
module tb_tenbase_t_phy_core;
    timeunit 1ns;
    timeprecision 1ps;
    import tenbase_t_phy_pkg::*;
    logic clk_sys = 0, rst_n = 0, serialMode = 0, fullDuplex = 0, statusRead = 0;
    logic lineRxLvl = 0, lineRxAct = 0, go = 0, txClk, rxClk, crs, col, linkValid, stB, stF;
    logic repeaterMode = 0, noiseCheckInhibit = 0;
    logic [3:0] nib = 4'h0;
    mac_tx_t macTx;
    mac_rx_t macRx;
    line_tx_t lineTx;
    int mismatches = 0, total_checks = 0, seed = 32'h32BE957C, n, i;
    tenbase_t_phy_core #(.NLP_PERIOD_CYC_P(400), .LINK_LOSS_CYC_P(2000)) u_dut (.clk_sys, .rst_n,
        .serialMode, .fullDuplex, .repeaterMode, .noiseCheckInhibit, .statusRead, .macTx,
        .txClk, .macRx, .rxClk, .crs, .col, .lineTx, .lineRxLvl, .lineRxAct, .linkValid,
        .linkStatusBasic(stB), .linkStatusFast(stF));
    mac_tx_model u_mac (.clk_sys, .txClk, .go, .nib, .macTx);
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic give_verdict;
        if (mismatches == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : chk
    task automatic chki(input string nm, input int e, input int g);
        total_checks++;
        if (g != e) begin
            mismatches++;
            $display("MISMATCH %s exp %0d got %0d", nm, e, g);
        end
    endtask : chki
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc
    // bounded wait on txClk; n ends as the cycles spent
    task automatic till(input logic v);
        for (n = 0; txClk !== v; n++) begin
            if (n > 40) begin
                mismatches++;
                give_verdict();
            end
            cyc(1);
        end
    endtask : till
    task automatic period(input logic ser);
        @(posedge clk_sys);
        serialMode <= ser;
        #1;
        till(1);
        till(0);
        till(1);
        till(0);
        chki("txClk high", (ser ? SER_DIV_CYC : MII_DIV_CYC) / 2, n);
        till(1);
        chki("txClk low", (ser ? SER_DIV_CYC : MII_DIV_CYC) / 2, n);
    endtask : period
    // one random nibble, sent twice when go rises while txClk is low, then the idle marker; the last copy is checked, bit0 first
    task automatic tx(input logic fd, input logic rp);
        logic [3:0] d;
        logic e;
        d = 4'($random(seed));
        @(posedge clk_sys);
        fullDuplex <= fd;
        repeaterMode <= rp;
        nib <= d;
        go <= 1;
        #1;
        till(1);
        till(0);
        till(1);
        @(posedge clk_sys);
        go <= 0;
        cyc(1);
        for (int k = 1; k <= 24; k++) begin
            e = k > 16 || (d[(k - 1) / 4] ^ ((k - 1) % 4 > 1));
            chk("lineTx.pos", e, lineTx.pos);
            chk("lineTx.neg", !e, lineTx.neg);
            chk("lineTx.drive", 1'b1, lineTx.drive);
            if (k == 4) chk("crs", !(fd || rp), crs);
            if (k == 4) chk("col", 1'b0, col);
            cyc(1);
        end
    endtask : tx
    task automatic pulses(input int p);
        repeat (p) begin
            @(posedge clk_sys);
            lineRxAct <= 1;
            repeat (4) @(posedge clk_sys);
            lineRxAct <= 0;
            repeat (40) @(posedge clk_sys);
        end
        #1;
    endtask : pulses
    // preamble 1010.. at two cycles per half bit, then the line high (idl) or low
    task automatic frame(input logic idl);
        for (i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            lineRxAct <= 1;
            lineRxLvl <= !i[1] ^ i[0];
            @(posedge clk_sys);
        end
        lineRxLvl <= idl;
        #1;
    endtask : frame
    initial begin
        #2500000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        chk("status", 1'b0, stB);
        rst_n <= 1;
        cyc(2);
        for (i = 0; i < 2; i++) period(i[0]);
        period(0);
        for (i = 0; i < 6; i++) tx(i[0], i[1]);
        pulses(7);
        chk("linkValid", 1'b0, linkValid);
        pulses(1);
        chk("linkValid", 1'b1, linkValid);
        chk("status", 1'b0, stB);
        @(posedge clk_sys);
        statusRead <= 1;
        @(posedge clk_sys);
        statusRead <= 0;
        cyc(2);
        chk("status basic", 1'b1, stB);
        chk("status fast", 1'b1, stF);
        cyc(1500);
        pulses(1);
        cyc(1500);
        chk("linkValid", 1'b1, linkValid);
        cyc(550);
        chk("linkValid", 1'b0, linkValid);
        chk("status", 1'b0, stB);
        @(posedge clk_sys);
        fullDuplex <= 1;
        frame(1);
        chk("crs", 1'b1, crs);
        chk("macRx.dv", 1'b1, macRx.dv);
        chki("macRx.data", 5, macRx.data);
        chk("linkValid", 1'b0, linkValid);
        repeat (10) @(posedge clk_sys);
        lineRxAct <= 0;
        lineRxLvl <= 0;
        cyc(20);
        chk("linkValid", 1'b1, linkValid);
        chk("crs", 1'b0, crs);
        chk("status", 1'b0, stB);
        cyc(2100);
        chk("linkValid", 1'b0, linkValid);
        frame(0);
        repeat (10) @(posedge clk_sys);
        lineRxAct <= 0;
        cyc(20);
        chk("linkValid", 1'b0, linkValid);
        @(posedge clk_sys);
        noiseCheckInhibit <= 1;
        frame(0);
        repeat (10) @(posedge clk_sys);
        lineRxAct <= 0;
        cyc(20);
        chk("linkValid", 1'b1, linkValid);
        give_verdict();
    end
endmodule : tb_tenbase_t_phy_core
